/* File: rtl/adcsc_defines.svh */
// Offsets, field positions and reset values of the step control block.
// Assumes inclusion by bare name from the rtl/ files.
`ifndef ADCSC_DEFINES_SVH
`define ADCSC_DEFINES_SVH
// ==========================================
// Register byte offsets
`define ADCSC_OFF_STEPCTL 4'h0
`define ADCSC_OFF_MUX 4'h4
`define ADCSC_OFF_STATUS 4'h8
`define ADCSC_OFF_MASK 4'hc
// ==========================================
// Step control field positions
`define ADCSC_BIT_LAST 29
`define ADCSC_BIT_IRQEN 30
`define ADCSC_BIT_TEMP 31
`define ADCSC_MUX_LSB 28
`define ADCSC_MUX_W 4
// ==========================================
// Reset values and timing
`define ADCSC_STEPCTL_RST 3'h0
`define ADCSC_MUX_RST 4'h0
`define ADCSC_CONV_CYCLES 4'h8
`endif

/* File: rtl/adcsc_pkg.sv */
// Types for the step control block.
// Assumes nothing beyond the defines header.
package adcsc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_DONE} adcsc_state_type;
endpackage

/* File: rtl/adcsc_conv_timer.sv */
// Conversion timer: pulses done a fixed number of cycles after start.
// Assumes start is a one-cycle pulse while idle.
`timescale 1ns/10ps
`include "adcsc_defines.svh"
module adcsc_conv_timer (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  output logic done
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic done_nxt;

  always_comb
  begin
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    if (start)
      cnt_nxt = `ADCSC_CONV_CYCLES;
    else if (cnt_r != 4'h0)
    begin
      cnt_nxt = cnt_r - 4'h1;
      done_nxt = (cnt_r == 4'h1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= 4'h0;
      done <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      done <= done_nxt;
    end
  end
endmodule

/* File: rtl/adcsc_top.sv */
// Eighth-step control of a sample sequencer with an Avalon-MM slave.
// Assumes one 50 MHz clock and an Avalon master honouring waitrequest.
//
// Summary of operation
// - Temp-select set: eighth step samples the temperature sensor.
// - Temp-select clear: eighth step samples the pin chosen by input select.
// - Irq-enable set: raw sequence interrupt set when step conversion ends.
// - Raw interrupt reaches the irq output only when its mask bit is set.
// - Single-step sequencer always treats its only step as last.
`timescale 1ns/10ps
`include "adcsc_defines.svh"
module adcsc_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Sequencer
  input wire logic step_go,
  input wire logic single_step_mode,
  output logic sample_temp,
  output logic [3:0] sample_pin,
  output logic sample_start,
  output logic seq_done,
  output logic next_step_go,
  // Interrupt
  output logic irq
);
  // ==========================================
  // Registers
  logic temp_select_step7_r, temp_select_step7_nxt;
  logic irq_enable_step7_r, irq_enable_step7_nxt;
  logic last_step_flag7_r, last_step_flag7_nxt;
  logic [3:0] mux_r, mux_nxt;
  logic raw_irq_seq0_r, raw_irq_seq0_nxt;
  logic irq_mask_seq0_r, irq_mask_seq0_nxt;
  logic [31:0] rdata_nxt;
  logic ack_r, ack_nxt;
  logic sample_temp_nxt, sample_start_nxt, seq_done_nxt, next_go_nxt;
  logic [3:0] sample_pin_nxt;
  adcsc_pkg::adcsc_state_type state_r, state_nxt;
  logic conv_done;
  logic eff_last;
  logic req;
  logic wr_hit;

  assign req = avs_read | avs_write;
  assign wr_hit = avs_write & ack_r;
  assign eff_last = last_step_flag7_r | single_step_mode;

  adcsc_conv_timer u_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(sample_start),
    .done(conv_done)
  );

  // ==========================================
  // Bus slave and register file
  always_comb
  begin
    temp_select_step7_nxt = temp_select_step7_r;
    irq_enable_step7_nxt = irq_enable_step7_r;
    last_step_flag7_nxt = last_step_flag7_r;
    mux_nxt = mux_r;
    irq_mask_seq0_nxt = irq_mask_seq0_r;
    raw_irq_seq0_nxt = raw_irq_seq0_r;
    ack_nxt = req & ~ack_r;
    rdata_nxt = 32'h0;
    if (wr_hit)
    begin
      unique case (avs_address)
        `ADCSC_OFF_STEPCTL:
        begin
          temp_select_step7_nxt = avs_writedata[`ADCSC_BIT_TEMP];
          irq_enable_step7_nxt = avs_writedata[`ADCSC_BIT_IRQEN];
          last_step_flag7_nxt = avs_writedata[`ADCSC_BIT_LAST];
        end
        `ADCSC_OFF_MUX:
          mux_nxt = avs_writedata[`ADCSC_MUX_LSB +: `ADCSC_MUX_W];
        `ADCSC_OFF_STATUS:
          if (avs_writedata[0])
            raw_irq_seq0_nxt = 1'b0;
        `ADCSC_OFF_MASK:
          irq_mask_seq0_nxt = avs_writedata[0];
        default:
          ;
      endcase
    end
    // Set wins over write-one-to-clear
    if (conv_done && irq_enable_step7_r)
      raw_irq_seq0_nxt = 1'b1;
    if (avs_read && !ack_r)
    begin
      unique case (avs_address)
        `ADCSC_OFF_STEPCTL:
        begin
          rdata_nxt[`ADCSC_BIT_TEMP] = temp_select_step7_r;
          rdata_nxt[`ADCSC_BIT_IRQEN] = irq_enable_step7_r;
          rdata_nxt[`ADCSC_BIT_LAST] = eff_last;
        end
        `ADCSC_OFF_MUX:
          rdata_nxt[`ADCSC_MUX_LSB +: `ADCSC_MUX_W] = mux_r;
        `ADCSC_OFF_STATUS:
          rdata_nxt[0] = raw_irq_seq0_r;
        `ADCSC_OFF_MASK:
          rdata_nxt[0] = irq_mask_seq0_r;
        default:
          rdata_nxt = 32'h0;
      endcase
    end
    else if (ack_r)
      rdata_nxt = avs_readdata;
  end

  // ==========================================
  // Step sequencing
  always_comb
  begin
    state_nxt = state_r;
    sample_start_nxt = 1'b0;
    sample_temp_nxt = sample_temp;
    sample_pin_nxt = sample_pin;
    seq_done_nxt = 1'b0;
    next_go_nxt = 1'b0;
    unique case (state_r)
      adcsc_pkg::ST_IDLE:
        if (step_go)
        begin
          sample_start_nxt = 1'b1;
          sample_temp_nxt = temp_select_step7_r;
          sample_pin_nxt = temp_select_step7_r ? 4'h0 : mux_r;
          state_nxt = adcsc_pkg::ST_CONV;
        end
      adcsc_pkg::ST_CONV:
        if (conv_done)
          state_nxt = adcsc_pkg::ST_DONE;
      adcsc_pkg::ST_DONE:
      begin
        seq_done_nxt = eff_last;
        next_go_nxt = ~eff_last;
        state_nxt = adcsc_pkg::ST_IDLE;
      end
      default:
        state_nxt = adcsc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      temp_select_step7_r <= 1'b0;
      irq_enable_step7_r <= 1'b0;
      last_step_flag7_r <= 1'b0;
      mux_r <= `ADCSC_MUX_RST;
      raw_irq_seq0_r <= 1'b0;
      irq_mask_seq0_r <= 1'b0;
      ack_r <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      irq <= 1'b0;
      state_r <= adcsc_pkg::ST_IDLE;
      sample_start <= 1'b0;
      sample_temp <= 1'b0;
      sample_pin <= 4'h0;
      seq_done <= 1'b0;
      next_step_go <= 1'b0;
    end
    else
    begin
      temp_select_step7_r <= temp_select_step7_nxt;
      irq_enable_step7_r <= irq_enable_step7_nxt;
      last_step_flag7_r <= last_step_flag7_nxt;
      mux_r <= mux_nxt;
      raw_irq_seq0_r <= raw_irq_seq0_nxt;
      irq_mask_seq0_r <= irq_mask_seq0_nxt;
      ack_r <= ack_nxt;
      // Idle high; low only in the cycle that completes a transfer
      avs_waitrequest <= ~ack_nxt;
      avs_readdata <= rdata_nxt;
      irq <= raw_irq_seq0_nxt & irq_mask_seq0_nxt;
      state_r <= state_nxt;
      sample_start <= sample_start_nxt;
      sample_temp <= sample_temp_nxt;
      sample_pin <= sample_pin_nxt;
      seq_done <= seq_done_nxt;
      next_step_go <= next_go_nxt;
    end
  end

  // ==========================================
  // Checks
  AST_TEMP_SRC: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_r == adcsc_pkg::ST_IDLE && step_go)
    |=> sample_temp == $past(temp_select_step7_r))
    else $error("temperature select not applied");
  AST_PIN_SRC: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_r == adcsc_pkg::ST_IDLE && step_go && !temp_select_step7_r)
    |=> sample_pin == $past(mux_r))
    else $error("pin select not applied");
  AST_IRQ_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (conv_done && irq_enable_step7_r) |=> raw_irq_seq0_r)
    else $error("raw flag not set");
  AST_IRQ_QUIET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!raw_irq_seq0_r && !(conv_done && irq_enable_step7_r))
    |=> !raw_irq_seq0_r)
    else $error("raw flag set without cause");
  AST_IRQ_MASK: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irq == (raw_irq_seq0_r & irq_mask_seq0_r))
    else $error("irq not gated by mask");
  AST_LAST_END: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (conv_done && eff_last) |=> ##1 (seq_done && !next_step_go))
    else $error("last step did not end sequence");
  AST_SINGLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (conv_done && single_step_mode) |=> ##1 !next_step_go)
    else $error("single step sequencer continued");
  AST_RESET_ZERO: assert property (@(posedge ref_clk)
    !rst_n |=> (!temp_select_step7_r && !irq_enable_step7_r &&
    !last_step_flag7_r))
    else $error("step bits not cleared by reset");
  COV_TEMP: cover property (@(posedge ref_clk) disable iff (!rst_n)
    sample_start && sample_temp);
  COV_IRQ: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(irq));
  COV_CONTINUE: cover property (@(posedge ref_clk) disable iff (!rst_n)
    next_step_go);
endmodule

/* File: bench/test_adc_sequence_step_control.sv */
// Self-checking bench for the eighth-step control block.
// Assumes the rtl/ files and their header are compiled first.
`timescale 1ns/10ps
module test_adc_sequence_step_control;
  // ==========
  // Signals
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic step_go = 1'b0;
  logic single_step_mode = 1'b0;
  logic sample_temp, sample_start, seq_done, next_step_go, irq;
  logic [3:0] sample_pin;
  logic t, ie, l, sm, mk;
  logic [3:0] pin;
  logic [31:0] exp_q[$];
  int failures = 0;
  int total_checks = 0;

  always #10 ref_clk = ~ref_clk;

  adcsc_top i_dut (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .step_go(step_go),
    .single_step_mode(single_step_mode),
    .sample_temp(sample_temp),
    .sample_pin(sample_pin),
    .sample_start(sample_start),
    .seq_done(seq_done),
    .next_step_go(next_step_go),
    .irq(irq)
  );

  // ==========
  // Reporting
  task end_sim;
    if (failures == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Oldest note; a result with no note is a mismatch
  task take(input logic [31:0] seen);
    if (exp_q.size() > 0)
      check(seen, exp_q.pop_front());
    else
    begin
      total_checks++;
      failures++;
      $display("Error at %0t: result %h with no note", $time, seen);
    end
  endtask

  // ==========
  // Drivers
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
           input logic [31:0] e);
    int n;
    if (!wr)
      exp_q.push_back(e);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0)
    begin
      failures++;
      end_sim();
    end
    else
    begin
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask

  task step(input logic [31:0] es, input logic [31:0] ee);
    int n;
    exp_q.push_back(es);
    exp_q.push_back(ee);
    @(posedge ref_clk);
    step_go <= 1'b1;
    @(posedge ref_clk);
    step_go <= 1'b0;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while ((seq_done | next_step_go) !== 1'b1 && n < 30);
    if ((seq_done | next_step_go) !== 1'b1)
    begin
      failures++;
      end_sim();
    end
    else
      @(posedge ref_clk);
  endtask

  // ==========
  // Monitor
  always @(posedge ref_clk)
  begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      take(avs_readdata);
    if (sample_start === 1'b1)
      take({27'h0, sample_temp, sample_pin});
    if ((seq_done | next_step_go) === 1'b1)
      take({29'h0, irq, seq_done, next_step_go});
  end

  // ==========
  // Sequence
  initial
  begin
    void'($urandom(32'hc75e));
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    bus(1'b0, 4'h0, 32'h0, 32'h0);
    bus(1'b0, 4'h4, 32'h0, 32'h0);
    bus(1'b0, 4'h8, 32'h0, 32'h0);
    bus(1'b0, 4'hc, 32'h0, 32'h0);
    bus(1'b0, 4'h1, 32'h0, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      t = i[0];
      l = i[1];
      sm = i[2];
      ie = i[1] ^ i[2];
      mk = i[0] ^ i[1];
      pin = 4'($urandom);
      single_step_mode <= sm;
      bus(1'b1, 4'h4, {pin, 28'($urandom)}, 32'h0);
      bus(1'b0, 4'h4, 32'h0, {pin, 28'h0});
      bus(1'b1, 4'h0, {t, ie, l, 29'($urandom)}, 32'h0);
      bus(1'b1, 4'hc, {31'h0, mk}, 32'h0);
      bus(1'b0, 4'hc, 32'h0, {31'h0, mk});
      bus(1'b0, 4'h0, 32'h0, {t, ie, l | sm, 29'h0});
      step({27'h0, t, t ? 4'h0 : pin},
           {29'h0, ie & mk, l | sm, ~(l | sm)});
      bus(1'b0, 4'h8, 32'h0, {31'h0, ie});
      bus(1'b1, 4'h8, 32'h1, 32'h0);
      bus(1'b0, 4'h8, 32'h0, 32'h0);
    end
    end_sim();
  end
endmodule
